// File: bsf_defines.svh
// opcode patterns, flag positions, reset values and cycle counts of the
// branch/skip/fractional-multiply execute block
// assumes 16-bit instruction words and a 16-bit word-addressed program counter
`ifndef BSF_DEFINES_SVH
`define BSF_DEFINES_SVH

// flag register bit positions
`define BSF_FLAG_C 3'd0
`define BSF_FLAG_Z 3'd1
`define BSF_FLAG_N 3'd2
`define BSF_FLAG_V 3'd3
`define BSF_FLAG_S 3'd4
`define BSF_FLAG_H 3'd5
`define BSF_FLAG_T 3'd6
`define BSF_FLAG_I 3'd7

// reset values
`define BSF_FLAGS_RST 8'h00
`define BSF_PC_RST 16'h0000

// instruction masks and match values
`define BSF_M_FRAC_MULT_UNSIGNED 16'hff88
`define BSF_V_FRAC_MULT_UNSIGNED_U 16'h0308
`define BSF_V_FRAC_MULT_UNSIGNED_S 16'h0380
`define BSF_V_FRAC_MULT_UNSIGNED_SU 16'h0388
`define BSF_M_REL 16'hf000
`define BSF_V_RELATIVE_JUMP 16'hc000
`define BSF_V_RELATIVE_SUBROUTINE_INVOKE 16'hd000
`define BSF_M_FULL 16'hffff
`define BSF_V_INDIRECT_JUMP 16'h9409
`define BSF_V_INDIRECT_SUBROUTINE_INVOKE 16'h9509
`define BSF_V_RET 16'h9508
`define BSF_V_INTERRUPT_EXIT 16'h9518
`define BSF_M_ABS 16'hfe0e
`define BSF_V_JMP 16'h940c
`define BSF_V_CALL 16'h940e
`define BSF_M_RR 16'hfc00
`define BSF_V_COMPARE_SKIP_EQUAL 16'h1000
`define BSF_V_CP 16'h1400
`define BSF_V_CPC 16'h0400
`define BSF_V_CPI 16'h3000
`define BSF_M_SBR 16'hfe08
`define BSF_V_SKIP_IF_REG_BIT_CLEAR 16'hfc00
`define BSF_V_SKIP_IF_REG_BIT_SET 16'hfe00
`define BSF_M_SBI 16'hff00
`define BSF_V_SKIP_IF_IO_BIT_CLEAR 16'h9900
`define BSF_V_SKIP_IF_IO_BIT_SET 16'h9b00
`define BSF_V_BRANCH_IF_FLAG_BIT_SET 16'hf000
`define BSF_V_BRANCH_IF_FLAG_BIT_CLEAR 16'hf400

// execution time of each instruction class, in clock cycles
`define BSF_CYC_ONE 3'd1
`define BSF_CYC_FRAC_MULT_UNSIGNED 3'd2
`define BSF_CYC_RELATIVE_JUMP 3'd2
`define BSF_CYC_INDIRECT_JUMP 3'd2
`define BSF_CYC_JMP 3'd3
`define BSF_CYC_RELATIVE_SUBROUTINE_INVOKE 3'd3
`define BSF_CYC_INDIRECT_SUBROUTINE_INVOKE 3'd3
`define BSF_CYC_CALL 3'd4
`define BSF_CYC_RET 3'd4
`define BSF_CYC_BR_TAKEN 3'd2
`define BSF_CYC_SKIP1 3'd2
`define BSF_CYC_SKIP2 3'd3

`endif

// File: bsf_pkg.sv
// types shared by the execute block and its multiplier
// assumes bsf_defines.svh is on the include path
package bsf_pkg;

	typedef enum logic [1:0]
	{
		BSF_ST_IDLE = 2'b01,
		BSF_ST_EXEC = 2'b10
	} bsf_state_t;

	typedef enum logic [1:0]
	{
		BSF_FM_UNSIGNED = 2'b00,
		BSF_FM_SIGNED = 2'b01,
		BSF_FM_SIGNED_UNSIGNED = 2'b10
	} bsf_frac_mult_unsigned_t;

	typedef struct packed {
		logic [15:0] prod;
		logic zero;
		logic carry;
	} bsf_mul_t;

	typedef struct packed {
		bsf_state_t state;
		logic [2:0] cnt;
		logic ready;
		logic [15:0] pc;
		logic [15:0] pc_pend;
		logic [7:0] flags;
		logic mul_pend;
		logic push_pend;
		logic pop_pend;
		logic iflag_pend;
		logic [15:0] ret_addr;
		logic done;
		logic push;
		logic pop;
		logic prod_wr;
		logic [15:0] prod;
	} bsf_core_t;

endpackage : bsf_pkg

// File: bsf_fracmul.sv
// fractional multiplier: doubled 8x8 product with zero and carry
// result is registered one clock after the operands are presented
`timescale 1ns/1ps
`default_nettype none

module bsf_fracmul
	import bsf_pkg::*;
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// operands
	input wire logic [7:0] i_a,
	input wire logic [7:0] i_b,
	input wire bsf_frac_mult_unsigned_t i_mode,
	// result
	output logic [15:0] o_prod,
	output logic o_zero,
	output logic o_carry
);

	bsf_mul_t s_r;
	bsf_mul_t s_nxt;

	always_comb
	begin
		logic signed [8:0] a_ext;
		logic signed [8:0] b_ext;
		logic signed [17:0] full;
		a_ext = (i_mode == BSF_FM_UNSIGNED) ? {1'b0, i_a} : {i_a[7], i_a};
		b_ext = (i_mode == BSF_FM_SIGNED) ? {i_b[7], i_b} : {1'b0, i_b};
		full = a_ext * b_ext;
		// carry is the product bit shifted out by the doubling
		s_nxt.carry = full[15];
		s_nxt.prod = {full[14:0], 1'b0};
		s_nxt.zero = (full[14:0] == 15'h0000);
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign o_prod = s_r.prod;
	assign o_zero = s_r.zero;
	assign o_carry = s_r.carry;

endmodule : bsf_fracmul

`default_nettype wire

// File: bsf_compare.sv
// subtract-without-store flag generator for the compare instructions
// purely combinational; the caller registers the flags
`timescale 1ns/1ps
`default_nettype none

module bsf_compare
(
	// operands
	input wire logic [7:0] i_a,
	input wire logic [7:0] i_b,
	input wire logic i_use_carry,
	input wire logic i_carry_in,
	input wire logic i_zero_in,
	// flags
	output logic o_zero,
	output logic o_neg,
	output logic o_ovf,
	output logic o_carry,
	output logic o_half
);

	logic [7:0] res;
	logic cin;

	assign cin = i_use_carry & i_carry_in;
	assign res = i_a - i_b - {7'h00, cin};
	// with carry-in the zero flag only stays set, so multi-byte compares chain
	assign o_zero = (res == 8'h00) & (~i_use_carry | i_zero_in);
	assign o_neg = res[7];
	assign o_ovf = (i_a[7] & ~i_b[7] & ~res[7]) | (~i_a[7] & i_b[7] & res[7]);
	assign o_carry = (~i_a[7] & i_b[7]) | (i_b[7] & res[7]) | (res[7] & ~i_a[7]);
	assign o_half = (~i_a[3] & i_b[3]) | (i_b[3] & res[3]) | (res[3] & ~i_a[3]);

endmodule : bsf_compare

`default_nettype wire

// File: bsf_exec.sv
// execute stage for fractional multiply, jumps, calls, returns, compares,
// skips and flag branches of an 8-bit core
// assumes fetch presents an instruction with its register operands already read,
// its second word for two-word forms, and whether the following one is two words
//
// How it works
// - fractional multiplies double product, set Z C
// - jumps: relative, via Z, absolute; 2/2/3 cycles
// - calls 3/3/4 cycles; returns pop pc, 4 cycles
// - equal compare skips next instruction, flags untouched
// - compares set Z N V C H, one cycle
// - register bit clear skips next instruction
// - register bit set skips next instruction
// - I/O bit clear skips, flags untouched
// - I/O bit set skips, flags untouched
// - branch on selected flag set: pc+k+1
// - branch on selected flag clear: pc+k+1
// - carry set/lower on C=1, clear/higher C=0
// - same-or-higher identical to carry-clear
// - signed ge when N xor V is 0
// - signed less when N xor V is 1
// - half-carry branches follow H
// - transfer-bit branches follow T
// - overflow branches follow V, no flag change
`timescale 1ns/1ps
`default_nettype none
`include "bsf_defines.svh"

module bsf_exec
	import bsf_pkg::*;
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// instruction from fetch
	input wire logic i_instr_valid,
	input wire logic [15:0] i_instr,
	input wire logic [15:0] i_instr_word2,
	input wire logic i_next_two_word,
	// operand values
	input wire logic [7:0] i_op_d,
	input wire logic [7:0] i_op_r,
	input wire logic [7:0] i_io_val,
	input wire logic [15:0] i_z_ptr,
	input wire logic [15:0] i_stack_pc,
	// status toward fetch
	output logic o_ready,
	output logic [15:0] o_pc,
	output logic o_done,
	output logic [7:0] o_flags,
	// product write to the R1:R0 pair
	output logic o_prod_wr,
	output logic [15:0] o_prod,
	// return stack
	output logic o_stack_push,
	output logic [15:0] o_ret_addr,
	output logic o_stack_pop
);

	bsf_core_t s_r;
	bsf_core_t s_nxt;

	bsf_frac_mult_unsigned_t mul_mode;
	logic [15:0] mul_prod;
	logic mul_zero;
	logic mul_carry;
	logic [7:0] cmp_b;
	logic cmp_use_carry;
	logic cmp_zero;
	logic cmp_neg;
	logic cmp_ovf;
	logic cmp_carry;
	logic cmp_half;

	// pc + k + 1 for a sign-extended word offset
	function automatic logic [15:0] bsf_rel_target(input logic [15:0] pc,
		input logic [15:0] off);
		bsf_rel_target = pc + off + 16'h0001;
	endfunction : bsf_rel_target

	function automatic logic bsf_match(input logic [15:0] instr,
		input logic [15:0] mask, input logic [15:0] val);
		bsf_match = ((instr & mask) == val);
	endfunction : bsf_match

	// the product is read one clock after acceptance, in the second cycle
	always_comb
	begin
		if (bsf_match(i_instr, `BSF_M_FRAC_MULT_UNSIGNED, `BSF_V_FRAC_MULT_UNSIGNED_S))
			mul_mode = BSF_FM_SIGNED;
		else if (bsf_match(i_instr, `BSF_M_FRAC_MULT_UNSIGNED, `BSF_V_FRAC_MULT_UNSIGNED_SU))
			mul_mode = BSF_FM_SIGNED_UNSIGNED;
		else
			mul_mode = BSF_FM_UNSIGNED;
	end

	bsf_fracmul u_fracmul
	(
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_a(i_op_d),
		.i_b(i_op_r),
		.i_mode(mul_mode),
		.o_prod(mul_prod),
		.o_zero(mul_zero),
		.o_carry(mul_carry)
	);

	// immediate compare takes its constant from the instruction
	assign cmp_b = bsf_match(i_instr, `BSF_M_REL, `BSF_V_CPI) ?
		{i_instr[11:8], i_instr[3:0]} : i_op_r;
	assign cmp_use_carry = bsf_match(i_instr, `BSF_M_RR, `BSF_V_CPC);

	bsf_compare u_compare
	(
		.i_a(i_op_d),
		.i_b(cmp_b),
		.i_use_carry(cmp_use_carry),
		.i_carry_in(s_r.flags[`BSF_FLAG_C]),
		.i_zero_in(s_r.flags[`BSF_FLAG_Z]),
		.o_zero(cmp_zero),
		.o_neg(cmp_neg),
		.o_ovf(cmp_ovf),
		.o_carry(cmp_carry),
		.o_half(cmp_half)
	);

	always_comb
	begin
		logic [2:0] cyc;
		logic [15:0] tgt;
		logic [15:0] seq;
		logic [15:0] skip_tgt;
		logic [2:0] skip_cyc;
		logic [7:0] flags_new;
		logic is_mul;
		logic push;
		logic pop;
		logic set_i;
		logic flag_bit;
		cyc = `BSF_CYC_ONE;
		seq = s_r.pc + 16'h0001;
		tgt = seq;
		flags_new = s_r.flags;
		is_mul = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		set_i = 1'b0;
		flag_bit = s_r.flags[i_instr[2:0]];
		// a skip steps over one or two words and costs a cycle per word
		skip_tgt = i_next_two_word ? (s_r.pc + 16'h0003) : (s_r.pc + 16'h0002);
		skip_cyc = i_next_two_word ? `BSF_CYC_SKIP2 : `BSF_CYC_SKIP1;
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		s_nxt.push = 1'b0;
		s_nxt.pop = 1'b0;
		s_nxt.prod_wr = 1'b0;
		case (s_r.state)
			BSF_ST_IDLE:
			begin
				if (i_instr_valid)
				begin
					if (bsf_match(i_instr, `BSF_M_FRAC_MULT_UNSIGNED, `BSF_V_FRAC_MULT_UNSIGNED_U) ||
						bsf_match(i_instr, `BSF_M_FRAC_MULT_UNSIGNED, `BSF_V_FRAC_MULT_UNSIGNED_S) ||
						bsf_match(i_instr, `BSF_M_FRAC_MULT_UNSIGNED, `BSF_V_FRAC_MULT_UNSIGNED_SU))
					begin
						cyc = `BSF_CYC_FRAC_MULT_UNSIGNED;
						is_mul = 1'b1;
					end
					else if (bsf_match(i_instr, `BSF_M_REL, `BSF_V_RELATIVE_JUMP))
					begin
						tgt = bsf_rel_target(s_r.pc, {{4{i_instr[11]}}, i_instr[11:0]});
						cyc = `BSF_CYC_RELATIVE_JUMP;
					end
					else if (bsf_match(i_instr, `BSF_M_FULL, `BSF_V_INDIRECT_JUMP))
					begin
						tgt = i_z_ptr;
						cyc = `BSF_CYC_INDIRECT_JUMP;
					end
					else if (bsf_match(i_instr, `BSF_M_ABS, `BSF_V_JMP))
					begin
						// only the low 16 target bits fit this program counter
						tgt = i_instr_word2;
						cyc = `BSF_CYC_JMP;
					end
					else if (bsf_match(i_instr, `BSF_M_REL, `BSF_V_RELATIVE_SUBROUTINE_INVOKE))
					begin
						tgt = bsf_rel_target(s_r.pc, {{4{i_instr[11]}}, i_instr[11:0]});
						cyc = `BSF_CYC_RELATIVE_SUBROUTINE_INVOKE;
						push = 1'b1;
						s_nxt.ret_addr = seq;
					end
					else if (bsf_match(i_instr, `BSF_M_FULL, `BSF_V_INDIRECT_SUBROUTINE_INVOKE))
					begin
						tgt = i_z_ptr;
						cyc = `BSF_CYC_INDIRECT_SUBROUTINE_INVOKE;
						push = 1'b1;
						s_nxt.ret_addr = seq;
					end
					else if (bsf_match(i_instr, `BSF_M_ABS, `BSF_V_CALL))
					begin
						tgt = i_instr_word2;
						cyc = `BSF_CYC_CALL;
						push = 1'b1;
						// return lands past the second word
						s_nxt.ret_addr = s_r.pc + 16'h0002;
					end
					else if (bsf_match(i_instr, `BSF_M_FULL, `BSF_V_RET) ||
						bsf_match(i_instr, `BSF_M_FULL, `BSF_V_INTERRUPT_EXIT))
					begin
						tgt = i_stack_pc;
						cyc = `BSF_CYC_RET;
						pop = 1'b1;
						// interrupt exit re-enables interrupts
						set_i = bsf_match(i_instr, `BSF_M_FULL, `BSF_V_INTERRUPT_EXIT);
					end
					else if (bsf_match(i_instr, `BSF_M_RR, `BSF_V_COMPARE_SKIP_EQUAL))
					begin
						if (i_op_d == i_op_r)
						begin
							tgt = skip_tgt;
							cyc = skip_cyc;
						end
					end
					else if (bsf_match(i_instr, `BSF_M_RR, `BSF_V_CP) ||
						bsf_match(i_instr, `BSF_M_RR, `BSF_V_CPC) ||
						bsf_match(i_instr, `BSF_M_REL, `BSF_V_CPI))
					begin
						// no result register is written, only the flags
						flags_new[`BSF_FLAG_Z] = cmp_zero;
						flags_new[`BSF_FLAG_N] = cmp_neg;
						flags_new[`BSF_FLAG_V] = cmp_ovf;
						flags_new[`BSF_FLAG_C] = cmp_carry;
						flags_new[`BSF_FLAG_H] = cmp_half;
					end
					else if (bsf_match(i_instr, `BSF_M_SBR, `BSF_V_SKIP_IF_REG_BIT_CLEAR))
					begin
						if (!i_op_r[i_instr[2:0]])
						begin
							tgt = skip_tgt;
							cyc = skip_cyc;
						end
					end
					else if (bsf_match(i_instr, `BSF_M_SBR, `BSF_V_SKIP_IF_REG_BIT_SET))
					begin
						if (i_op_r[i_instr[2:0]])
						begin
							tgt = skip_tgt;
							cyc = skip_cyc;
						end
					end
					else if (bsf_match(i_instr, `BSF_M_SBI, `BSF_V_SKIP_IF_IO_BIT_CLEAR))
					begin
						if (!i_io_val[i_instr[2:0]])
						begin
							tgt = skip_tgt;
							cyc = skip_cyc;
						end
					end
					else if (bsf_match(i_instr, `BSF_M_SBI, `BSF_V_SKIP_IF_IO_BIT_SET))
					begin
						if (i_io_val[i_instr[2:0]])
						begin
							tgt = skip_tgt;
							cyc = skip_cyc;
						end
					end
					else if (bsf_match(i_instr, `BSF_M_RR, `BSF_V_BRANCH_IF_FLAG_BIT_SET) ||
						bsf_match(i_instr, `BSF_M_RR, `BSF_V_BRANCH_IF_FLAG_BIT_CLEAR))
					begin
						// all named flag branches are aliases of these two: the
						// flag index picks Z, C, N, V, H, T, I; the signed pair at the
						// S index tests N xor V directly, the S bit itself is not read
						if (i_instr[2:0] == `BSF_FLAG_S)
							flag_bit = s_r.flags[`BSF_FLAG_N] ^ s_r.flags[`BSF_FLAG_V];
						else
							flag_bit = s_r.flags[i_instr[2:0]];
						if (flag_bit != i_instr[10])
						begin
							tgt = bsf_rel_target(s_r.pc, {{9{i_instr[9]}}, i_instr[9:3]});
							cyc = `BSF_CYC_BR_TAKEN;
						end
					end
					// other opcodes belong to other units and just advance here
					if (cyc == `BSF_CYC_ONE)
					begin
						s_nxt.pc = tgt;
						s_nxt.flags = flags_new;
						s_nxt.done = 1'b1;
					end
					else
					begin
						s_nxt.state = BSF_ST_EXEC;
						s_nxt.ready = 1'b0;
						s_nxt.cnt = cyc - 3'd1;
						s_nxt.pc_pend = tgt;
						s_nxt.mul_pend = is_mul;
						s_nxt.push_pend = push;
						s_nxt.pop_pend = pop;
						s_nxt.iflag_pend = set_i;
					end
				end
			end
			BSF_ST_EXEC:
			begin
				if (s_r.cnt == 3'd1)
				begin
					s_nxt.state = BSF_ST_IDLE;
					s_nxt.ready = 1'b1;
					s_nxt.cnt = 3'd0;
					s_nxt.pc = s_r.pc_pend;
					s_nxt.done = 1'b1;
					s_nxt.push = s_r.push_pend;
					s_nxt.pop = s_r.pop_pend;
					if (s_r.iflag_pend)
						s_nxt.flags[`BSF_FLAG_I] = 1'b1;
					if (s_r.mul_pend)
					begin
						// only zero and carry move; R1:R0 gets the doubled product
						s_nxt.prod = mul_prod;
						s_nxt.prod_wr = 1'b1;
						s_nxt.flags[`BSF_FLAG_Z] = mul_zero;
						s_nxt.flags[`BSF_FLAG_C] = mul_carry;
					end
				end
				else
				begin
					s_nxt.cnt = s_r.cnt - 3'd1;
				end
			end
			default:
			begin
				s_nxt = '0;
				s_nxt.state = BSF_ST_IDLE;
				s_nxt.ready = 1'b1;
				s_nxt.pc = `BSF_PC_RST;
				s_nxt.flags = `BSF_FLAGS_RST;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			s_r <= '0;
			s_r.state <= BSF_ST_IDLE;
			s_r.ready <= 1'b1;
			s_r.pc <= `BSF_PC_RST;
			s_r.flags <= `BSF_FLAGS_RST;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign o_ready = s_r.ready;
	assign o_pc = s_r.pc;
	assign o_done = s_r.done;
	assign o_flags = s_r.flags;
	assign o_prod_wr = s_r.prod_wr;
	assign o_prod = s_r.prod;
	assign o_stack_push = s_r.push;
	assign o_ret_addr = s_r.ret_addr;
	assign o_stack_pop = s_r.pop;

endmodule : bsf_exec

`default_nettype wire

// File: bsf_exec_asserts.sv
// port-level checks of the execute block, attached by bind
// assumes bsf_defines.svh on the include path and one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "bsf_defines.svh"

module bsf_exec_asserts
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// inputs watched
	input wire logic i_instr_valid,
	input wire logic [15:0] i_instr,
	input wire logic [15:0] i_instr_word2,
	input wire logic [15:0] i_stack_pc,
	// outputs watched
	input wire logic o_ready,
	input wire logic [15:0] o_pc,
	input wire logic o_done,
	input wire logic [7:0] o_flags,
	input wire logic o_prod_wr,
	input wire logic o_stack_push,
	input wire logic [15:0] o_ret_addr,
	input wire logic o_stack_pop
);
	logic acc;
	logic sk;
	logic br;
	logic fsel;
	logic cond;
	logic [15:0] apc;
	logic [15:0] ains;
	logic [7:0] afl;
	logic [2:0] cnt;

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);

	assign acc = i_instr_valid && o_ready;
	assign sk = ((ains & `BSF_M_RR) == `BSF_V_COMPARE_SKIP_EQUAL) || ((ains & `BSF_M_SBR) == `BSF_V_SKIP_IF_REG_BIT_CLEAR)
		|| ((ains & `BSF_M_SBR) == `BSF_V_SKIP_IF_REG_BIT_SET) || ((ains & `BSF_M_SBI) == `BSF_V_SKIP_IF_IO_BIT_CLEAR)
		|| ((ains & `BSF_M_SBI) == `BSF_V_SKIP_IF_IO_BIT_SET);
	assign br = (ains & 16'hf800) == `BSF_V_BRANCH_IF_FLAG_BIT_SET;
	// signed flag index tests n xor v, as the block keeps no separate sign flag
	assign fsel = (ains[2:0] == 3'd4) ? (afl[2] ^ afl[3]) : afl[ains[2:0]];
	assign cond = ains[10] ? !fsel : fsel;

	// snapshot at accept; cnt equals the edges run when done shows
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			apc <= 16'h0000;
			ains <= 16'h0000;
			afl <= 8'h00;
			cnt <= 3'h0;
		end
		else if (acc)
		begin
			apc <= o_pc;
			ains <= i_instr;
			afl <= o_flags;
			cnt <= 3'h1;
		end
		else if (cnt != 3'h7)
			cnt <= cnt + 3'h1;
	end

	a_frac_mult_unsigned_two_cyc: assert property (
		(acc && ((i_instr & `BSF_M_FRAC_MULT_UNSIGNED) inside {`BSF_V_FRAC_MULT_UNSIGNED_U, `BSF_V_FRAC_MULT_UNSIGNED_S, `BSF_V_FRAC_MULT_UNSIGNED_SU}))
		|-> ##1 !o_ready ##1 (o_done && o_prod_wr && o_ready)) else $error("multiply timing");
	a_relative_jump_target: assert property (
		(acc && (i_instr & `BSF_M_REL) == `BSF_V_RELATIVE_JUMP) |-> ##1 !o_ready ##1
		(o_done && o_pc == apc + {{4{ains[11]}}, ains[11:0]} + 16'h0001)) else $error("jump target");
	a_call_four: assert property (
		(acc && (i_instr & `BSF_M_ABS) == `BSF_V_CALL) |-> ##1 !o_ready [*3] ##1
		(o_done && o_stack_push && o_pc == $past(i_instr_word2, 4) && o_ret_addr == apc + 16'h0002))
		else $error("call timing");
	a_ret_pop: assert property (
		(acc && (i_instr == `BSF_V_RET || i_instr == `BSF_V_INTERRUPT_EXIT)) |-> ##4
		(o_done && o_stack_pop && o_pc == $past(i_stack_pc, 4))) else $error("return timing");
	a_cmp_one: assert property (
		(acc && ((i_instr & `BSF_M_RR) inside {`BSF_V_CP, `BSF_V_CPC} || i_instr[15:12] == 4'h3))
		|=> (o_done && o_pc == apc + 16'h0001)) else $error("compare timing");
	a_skip_advance: assert property (
		(o_done && sk) |-> (cnt != 3'h0 && o_pc - apc == {13'h0000, cnt})) else $error("skip advance");
	a_noflag_change: assert property (
		(o_done && (sk || br)) |-> o_flags == afl) else $error("flags changed");
	a_branch_cond: assert property (
		(o_done && br) |-> ((cnt == 3'h1 && !cond && o_pc == apc + 16'h0001) || (cnt == 3'h2
		&& cond && o_pc == apc + {{9{ains[9]}}, ains[9:3]} + 16'h0001))) else $error("branch result");
endmodule : bsf_exec_asserts

bind bsf_exec bsf_exec_asserts chk_u (.*);
`default_nettype wire

// File: bsf_fetch_model.sv
// fetch-side model: offers one instruction when told, holds it until taken
// assumes the bench pulses i_load only while nothing is on offer
`timescale 1ns/1ps
`default_nettype none

module bsf_fetch_model
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// bench side
	input wire logic i_load,
	input wire logic [15:0] i_word,
	input wire logic [15:0] i_word2,
	// execute side
	input wire logic i_ready,
	output logic o_valid,
	output logic [15:0] o_instr,
	output logic [15:0] o_word2
);
	// released words turn to their inverse so a late sample is caught
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_valid <= 1'b0;
			o_instr <= 16'hffff;
			o_word2 <= 16'hffff;
		end
		else if (i_load)
		begin
			o_valid <= 1'b1;
			o_instr <= i_word;
			o_word2 <= i_word2;
		end
		else if (o_valid && i_ready)
		begin
			o_valid <= 1'b0;
			o_instr <= ~o_instr;
			o_word2 <= ~o_word2;
		end
	end
endmodule : bsf_fetch_model
`default_nettype wire

// File: bsf_exec_tb_top.sv
// self-checking bench of the execute block behind a fetch model
// assumes the design, the checker and the fetch model compiled before
`timescale 1ns/1ps
`default_nettype none
`include "bsf_defines.svh"

module bsf_exec_tb_top;
	logic i_ref_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic ld = 1'b0;
	logic nw = 1'b0;
	logic [15:0] wd = 16'h0000;
	logic [15:0] w2 = 16'h0000;
	logic [7:0] od = 8'h00;
	logic [7:0] opr = 8'h00;
	logic valid, ready, done, prod_wr, push, pop;
	logic [15:0] instr, word2, pc, prod, ret_addr;
	logic [7:0] flags;
	logic [15:0] epc = 16'h0000;
	logic [7:0] fl = 8'h00;
	int failures = 0;
	int checks = 0;
	int cycles = 0;

	always #2 i_ref_clk = ~i_ref_clk;

	bsf_fetch_model fetch_u (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_load(ld), .i_word(wd),
		.i_word2(w2), .i_ready(ready), .o_valid(valid), .o_instr(instr), .o_word2(word2));
	bsf_exec dut_u (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_instr_valid(valid), .i_instr(instr),
		.i_instr_word2(word2), .i_next_two_word(nw), .i_op_d(od), .i_op_r(opr), .i_io_val(opr),
		.i_z_ptr(16'h1234), .i_stack_pc(16'h0abc), .o_ready(ready), .o_pc(pc), .o_done(done),
		.o_flags(flags), .o_prod_wr(prod_wr), .o_prod(prod), .o_stack_push(push),
		.o_ret_addr(ret_addr), .o_stack_pop(pop));

	task automatic summarize;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// operands stay put until the next request, the block samples them at accept only
	task automatic run(input logic [15:0] ins, input logic [15:0] sec, input logic [7:0] a,
		input logic [7:0] b, input logic t, output int n);
		@(posedge i_ref_clk);
		wd <= ins;
		w2 <= sec;
		od <= a;
		opr <= b;
		nw <= t;
		ld <= 1'b1;
		@(posedge i_ref_clk);
		ld <= 1'b0;
		n = 0;
		#1;
		while (n < 8 && done !== 1'b1)
		begin
			@(posedge i_ref_clk);
			n++;
			#1;
		end
	endtask : run

	task automatic chk_end(input int n, input int c);
		chk("cycles", 16'(n), 16'(c));
		chk("pc", pc, epc);
		chk("flags", 16'(flags), 16'(fl));
	endtask : chk_end

	task automatic cmp_model(input logic [7:0] a, input logic [7:0] b, input logic cc);
		logic [7:0] r;
		logic [7:0] bw;
		r = a - b - 8'(cc & fl[0]);
		bw = (~a & b) | (b & r) | (r & ~a);
		fl[1] = (r == 8'h00) && (!cc || fl[1]);
		fl[0] = bw[7];
		fl[2] = r[7];
		fl[3] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
		fl[5] = bw[3];
	endtask : cmp_model

	task automatic t_frac_mult_unsigned;
		logic [15:0] op [4] = '{`BSF_V_FRAC_MULT_UNSIGNED_U, `BSF_V_FRAC_MULT_UNSIGNED_S, `BSF_V_FRAC_MULT_UNSIGNED_SU, `BSF_V_FRAC_MULT_UNSIGNED_U};
		logic [7:0] av [4] = '{8'h80, 8'hff, 8'hff, 8'h00};
		logic [7:0] bv [4] = '{8'h80, 8'hff, 8'h02, 8'h55};
		logic [15:0] pv [4] = '{16'h8000, 16'h0002, 16'hfffc, 16'h0000};
		logic [1:0] zc [4] = '{2'b00, 2'b00, 2'b01, 2'b10};
		int n;
		for (int i = 0; i < 4; i++)
		begin
			run(op[i], 16'h0000, av[i], bv[i], 1'b0, n);
			epc = epc + 16'h0001;
			fl[1:0] = zc[i];
			chk_end(n, 2);
			chk("product", prod, pv[i]);
			chk("product write", 16'(prod_wr), 16'h0001);
		end
	endtask : t_frac_mult_unsigned

	task automatic t_flow;
		logic [15:0] op [9] = '{16'hc010, 16'hcff8, `BSF_V_INDIRECT_JUMP, `BSF_V_JMP, 16'hd005,
			`BSF_V_INDIRECT_SUBROUTINE_INVOKE, `BSF_V_CALL, `BSF_V_RET, `BSF_V_INTERRUPT_EXIT};
		int cy [9] = '{2, 2, 2, 3, 3, 3, 4, 4, 4};
		logic [15:0] sec;
		logic [15:0] ra;
		int n;
		for (int i = 0; i < 9; i++)
		begin
			sec = (i == 3) ? 16'h0200 : 16'h0300;
			run(op[i], sec, 8'h00, 8'h00, 1'b0, n);
			// the absolute call returns past its second word
			ra = epc + ((i == 6) ? 16'h0002 : 16'h0001);
			case (i)
				0, 1, 4: epc = epc + {{4{op[i][11]}}, op[i][11:0]} + 16'h0001;
				2, 5: epc = 16'h1234;
				3, 6: epc = sec;
				default: epc = 16'h0abc;
			endcase
			fl[7] = fl[7] | (i == 8);
			chk_end(n, cy[i]);
			chk("push", 16'(push), 16'(i inside {4, 5, 6}));
			chk("pop", 16'(pop), 16'(i > 6));
			if (i inside {4, 5, 6})
				chk("return address", ret_addr, ra);
		end
	endtask : t_flow

	task automatic t_cmp;
		logic [15:0] op [6] = '{`BSF_V_CP, `BSF_V_CPC, `BSF_V_CP, `BSF_V_CPC, 16'h3401, `BSF_V_CP};
		logic [7:0] av [6] = '{8'h05, 8'h00, 8'h10, 8'h20, 8'h40, 8'h80};
		logic [7:0] bv [6] = '{8'h05, 8'h00, 8'h20, 8'h1f, 8'h41, 8'h01};
		int n;
		for (int i = 0; i < 6; i++)
		begin
			run(op[i], 16'h0000, av[i], bv[i], 1'b0, n);
			cmp_model(av[i], bv[i], op[i] == `BSF_V_CPC);
			epc = epc + 16'h0001;
			chk_end(n, 1);
		end
	endtask : t_cmp

	// a not-taken skip also sees a two-word follower, which must not matter
	task automatic t_skip;
		logic [15:0] op [5] = '{`BSF_V_COMPARE_SKIP_EQUAL, 16'hfc05, 16'hfe05, 16'h9905, 16'h9b05};
		logic [7:0] b;
		int n;
		for (int k = 0; k < 5; k++)
			for (int v = 0; v < 3; v++)
			begin
				b = ((v != 0) ^ (k == 1 || k == 3)) ? 8'h20 : 8'h00;
				if (k == 0)
					b = (v != 0) ? 8'h3c : 8'h3d;
				run(op[k], 16'h0000, 8'h3c, b, v != 1, n);
				epc = epc + 16'(v + 1);
				chk_end(n, v + 1);
			end
	endtask : t_skip

	task automatic t_branch;
		logic [7:0] av [3] = '{8'h80, 8'h01, 8'h05};
		logic [7:0] bv [3] = '{8'h01, 8'h02, 8'h05};
		logic [6:0] k;
		logic c;
		int n;
		for (int j = 0; j < 3; j++)
		begin
			run(`BSF_V_CP, 16'h0000, av[j], bv[j], 1'b0, n);
			cmp_model(av[j], bv[j], 1'b0);
			epc = epc + 16'h0001;
			for (int s = 0; s < 16; s++)
			begin
				k = s[0] ? 7'h7c : 7'h05;
				c = ((s[2:0] == 3'd4) ? (fl[2] ^ fl[3]) : fl[s[2:0]]) ^ s[3];
				run(`BSF_V_BRANCH_IF_FLAG_BIT_SET | {5'h00, s[3], k, s[2:0]}, 16'h0000, 8'h00, 8'h00, 1'b0, n);
				epc = epc + (c ? {{9{k[6]}}, k} + 16'h0001 : 16'h0001);
				chk_end(n, c ? 2 : 1);
			end
		end
	endtask : t_branch

	always @(posedge i_ref_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			failures++;
			summarize();
		end
	end

	initial
	begin
		repeat (4) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		#1;
		chk("reset state", {ready, done, prod_wr, push, pop, 3'h0, flags}, 16'h8000);
		chk("reset pc", pc | prod | ret_addr, 16'h0000);
		t_frac_mult_unsigned();
		t_flow();
		t_cmp();
		t_skip();
		t_branch();
		summarize();
	end
endmodule : bsf_exec_tb_top
`default_nettype wire
